// [logic/rsec_delay.sv]
`timescale 1ns/100ps
`default_nettype none

module rsec_delay (
    input wire logic clk_i,  // System clock
    input wire logic srst_i, // Synchronous reset
    rsec_if.timer tmr        // Request, delays and timebase
);
    import rsec_pkg::*;

    rsec_state_t state_q, state_d;
    rsec_ms_t cnt_q, cnt_d;
    logic restart_d;

    wire last_ms = tmr.ms_tick && (cnt_q == 7'h01);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        restart_d = 1'b0;
        case (state_q)
            RS_OFF: begin
                if (tmr.req) begin
                    cnt_d = tmr.on_ms;
                    restart_d = 1'b1;
                    state_d = (tmr.on_ms == 7'h00) ? RS_ON : RS_WAIT_ON;
                end
            end
            RS_WAIT_ON: begin
                if (!tmr.req) begin
                    // Request dropped early: abandon the pending turn-on
                    cnt_d = 7'h00;
                    state_d = RS_OFF;
                end else if (last_ms) begin
                    cnt_d = 7'h00;
                    state_d = RS_ON;
                end else if (tmr.ms_tick) begin
                    cnt_d = cnt_q - 7'h01;
                end
            end
            RS_ON: begin
                if (!tmr.req) begin
                    cnt_d = tmr.off_ms;
                    restart_d = 1'b1;
                    state_d = (tmr.off_ms == 7'h00) ? RS_OFF : RS_WAIT_OFF;
                end
            end
            RS_WAIT_OFF: begin
                if (tmr.req) begin
                    cnt_d = 7'h00;
                    state_d = RS_ON;
                end else if (last_ms) begin
                    cnt_d = 7'h00;
                    state_d = RS_OFF;
                end else if (tmr.ms_tick) begin
                    cnt_d = cnt_q - 7'h01;
                end
            end
            default: begin
                cnt_d = 7'h00;
                state_d = RS_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_q <= RS_OFF;
            cnt_q <= 7'h00;
            tmr.restart <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            tmr.restart <= restart_d;
        end
    end

    // Enable holds through the off delay, stays low through the on delay
    assign tmr.en = (state_q == RS_ON) || (state_q == RS_WAIT_OFF);
    assign tmr.busy = (state_q == RS_WAIT_ON) || (state_q == RS_WAIT_OFF);
    assign tmr.remain = cnt_q;
endmodule

`default_nettype wire

// [logic/rsec_dummy_never.sv]
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// [logic/rsec_if.sv]
`timescale 1ns/100ps
`default_nettype none

interface rsec_if;
    import rsec_pkg::*;

    logic req;
    logic ms_tick;
    rsec_ms_t on_ms;
    rsec_ms_t off_ms;
    logic restart;
    logic en;
    logic busy;
    rsec_ms_t remain;

    modport ctrl (
        output req, ms_tick, on_ms, off_ms,
        input restart, en, busy, remain
    );
    modport timer (
        input req, ms_tick, on_ms, off_ms,
        output restart, en, busy, remain
    );
endinterface

`default_nettype wire

// [logic/rsec_params.svh]
`ifndef RSEC_PARAMS_SVH
`define RSEC_PARAMS_SVH

// Register offsets
`define RSEC_ADDR_MASK_A 8'h16
`define RSEC_ADDR_SRC_MASK_B 8'h17
`define RSEC_ADDR_EDGE_DLY 8'h18

// Reset images
`define RSEC_RST_MASK_A 8'h00
`define RSEC_RST_SRC_MASK_B 8'hc0
`define RSEC_RST_EDGE_DLY 8'h00

// Field positions in the second register
`define RSEC_B_MASK_SWB1_BIT 0
`define RSEC_B_MASK_SWB2_LDO1_BIT 1
`define RSEC_B_SRC_LSB 2
`define RSEC_B_SRC_MSB 4
`define RSEC_B_STEP_BIT 5

// Field positions in the third register
`define RSEC_D_ON_LSB 0
`define RSEC_D_ON_MSB 2
`define RSEC_D_OFF_LSB 3
`define RSEC_D_OFF_MSB 5

// Enable source codes
`define RSEC_SRC_PIN1 3'h0
`define RSEC_SRC_PIN2 3'h1
`define RSEC_SRC_PIN5 3'h2
`define RSEC_SRC_PIN4 3'h3
`define RSEC_SRC_PIN3 3'h4
`define RSEC_SRC_PIN3_4 3'h5
`define RSEC_SRC_PIN6 3'h6
`define RSEC_SRC_ALWAYS 3'h7

// Delay code to milliseconds
`define RSEC_DLY0_MS 7'h00
`define RSEC_DLY1_MS 7'h02
`define RSEC_DLY2_MS 7'h04
`define RSEC_DLY3_MS 7'h08
`define RSEC_DLY4_MS 7'h10
`define RSEC_DLY5_MS 7'h18
`define RSEC_DLY6_MS 7'h20
`define RSEC_DLY7_MS 7'h40

// Timebase
`define RSEC_CLK_HZ 125000000
`define RSEC_TICK_MS 1
`define RSEC_MS_CYCLES ((`RSEC_CLK_HZ / 1000) * `RSEC_TICK_MS)

`endif

// [logic/rsec_pkg.sv]
package rsec_pkg;

    typedef logic [7:0] rsec_byte_t;
    typedef logic [9:0] rsec_pg_vec_t;
    typedef logic [5:0] rsec_pin_vec_t;
    typedef logic [6:0] rsec_ms_t;

    typedef enum logic [1:0] {
        RS_OFF,
        RS_WAIT_ON,
        RS_ON,
        RS_WAIT_OFF
    } rsec_state_t;

endpackage

// [logic/rsec_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "rsec_params.svh"

module rsec_top #(
    parameter int MS_CYCLES = `RSEC_MS_CYCLES // Clock cycles per ms
) (
    input wire logic clk_i,                        // 125 MHz clock
    input wire logic srst_i,                       // Sync reset
    input wire logic [7:0] reg_addr_i,             // Register offset
    input wire logic reg_wr_i,                     // Write strobe
    input wire logic reg_rd_i,                     // Read strobe
    input wire rsec_pkg::rsec_byte_t reg_wdata_i,  // Write data
    output logic [7:0] reg_rdata_o,                // Read data
    output logic reg_rvalid_o,                     // Read data valid
    output logic reg_err_o,                        // Unmapped access
    input wire rsec_pkg::rsec_pin_vec_t ctl_pin_i, // Control pins 1..6
    input wire rsec_pkg::rsec_pg_vec_t rail_pg_i,  // Other power-goods
    output logic rail6_en_o,                       // Delayed enable
    output logic rail6_step_25mv_o,                // Step size select
    output logic rail6_request_o,                  // Undelayed request
    output logic rail6_delay_busy_o                // Delay running
);
    import rsec_pkg::*;

    localparam int DIV_W = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);

    // Power-good input order
    localparam int PG_RAIL1 = 0;
    localparam int PG_LSW_A = 5;
    localparam int PG_LDO2 = 6;
    localparam int PG_LDO3 = 7;
    localparam int PG_SWB1 = 8;
    localparam int PG_SWB2_LDO1 = 9;
    localparam int PG_N = 10;

    rsec_byte_t mask_a_q;
    rsec_byte_t src_mask_b_q;
    rsec_byte_t edge_dly_q;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic err_q;
    logic [DIV_W-1:0] div_q;
    logic req_q;

    rsec_if tif ();

    // Register decode
    wire hit_a = (reg_addr_i == `RSEC_ADDR_MASK_A);
    wire hit_b = (reg_addr_i == `RSEC_ADDR_SRC_MASK_B);
    wire hit_d = (reg_addr_i == `RSEC_ADDR_EDGE_DLY);
    wire hit_any = hit_a || hit_b || hit_d;
    wire wr_a = reg_wr_i && hit_a;
    wire wr_b = reg_wr_i && hit_b;
    wire wr_d = reg_wr_i && hit_d;
    wire bad_access = (reg_wr_i || reg_rd_i) && !hit_any;
    wire [7:0] rd_mux = hit_a ? mask_a_q :
                        hit_b ? src_mask_b_q :
                        hit_d ? edge_dly_q : 8'h00;

    // Whole-byte storage keeps reserved bits readable and writable
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mask_a_q <= `RSEC_RST_MASK_A;
            src_mask_b_q <= `RSEC_RST_SRC_MASK_B;
            edge_dly_q <= `RSEC_RST_EDGE_DLY;
        end else begin
            if (wr_a) begin
                mask_a_q <= reg_wdata_i;
            end
            if (wr_b) begin
                src_mask_b_q <= reg_wdata_i;
            end
            if (wr_d) begin
                edge_dly_q <= reg_wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd_i;
            err_q <= bad_access;
            if (reg_rd_i) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // Fields
    wire [2:0] rail6_enable_source =
        src_mask_b_q[`RSEC_B_SRC_MSB:`RSEC_B_SRC_LSB];
    wire rail6_voltage_step = src_mask_b_q[`RSEC_B_STEP_BIT];
    wire [2:0] rail6_off_delay = edge_dly_q[`RSEC_D_OFF_MSB:`RSEC_D_OFF_LSB];
    wire [2:0] rail6_on_delay = edge_dly_q[`RSEC_D_ON_MSB:`RSEC_D_ON_LSB];
    wire mask_switch_b1_pg = src_mask_b_q[`RSEC_B_MASK_SWB1_BIT];
    wire mask_switch_b2_ldo1_pg = src_mask_b_q[`RSEC_B_MASK_SWB2_LDO1_BIT];

    // Mask vector aligned with rail_pg_i
    wire [PG_N-1:0] pg_mask;
    assign pg_mask[PG_LSW_A-1:PG_RAIL1] = mask_a_q[4:0];
    assign pg_mask[PG_LSW_A] = mask_a_q[5];
    assign pg_mask[PG_LDO2] = mask_a_q[6];
    assign pg_mask[PG_LDO3] = mask_a_q[7];
    assign pg_mask[PG_SWB1] = mask_switch_b1_pg;
    assign pg_mask[PG_SWB2_LDO1] = mask_switch_b2_ldo1_pg;

    // A masked rail counts as good; an unmasked one must really be good
    wire [PG_N-1:0] pg_term;
    genvar g;
    generate
        for (g = 0; g < PG_N; g++) begin : g_pg
            assign pg_term[g] = pg_mask[g] | rail_pg_i[g];
        end
    endgenerate
    wire pg_all_ok = &pg_term;

    // Enable source multiplexer
    logic pin_sel;
    always_comb begin
        case (rail6_enable_source)
            `RSEC_SRC_PIN1: pin_sel = ctl_pin_i[0];
            `RSEC_SRC_PIN2: pin_sel = ctl_pin_i[1];
            `RSEC_SRC_PIN5: pin_sel = ctl_pin_i[4];
            `RSEC_SRC_PIN4: pin_sel = ctl_pin_i[3];
            `RSEC_SRC_PIN3: pin_sel = ctl_pin_i[2];
            `RSEC_SRC_PIN3_4: pin_sel = ctl_pin_i[2] & ctl_pin_i[3];
            `RSEC_SRC_PIN6: pin_sel = ctl_pin_i[5];
            `RSEC_SRC_ALWAYS: pin_sel = 1'b1;
            default: pin_sel = 1'b0;
        endcase
    end

    wire enable_cond = pin_sel & pg_all_ok;

    function automatic rsec_ms_t dly_ms(input logic [2:0] code);
        case (code)
            3'h0: dly_ms = `RSEC_DLY0_MS;
            3'h1: dly_ms = `RSEC_DLY1_MS;
            3'h2: dly_ms = `RSEC_DLY2_MS;
            3'h3: dly_ms = `RSEC_DLY3_MS;
            3'h4: dly_ms = `RSEC_DLY4_MS;
            3'h5: dly_ms = `RSEC_DLY5_MS;
            3'h6: dly_ms = `RSEC_DLY6_MS;
            3'h7: dly_ms = `RSEC_DLY7_MS;
            default: dly_ms = `RSEC_DLY0_MS;
        endcase
    endfunction

    // Request registered once so the timer sees a clean level
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            req_q <= 1'b0;
        end else begin
            req_q <= enable_cond;
        end
    end

    // Millisecond divider, realigned whenever a delay starts
    // No tick in the restart cycle, so a new delay never loses its first ms
    wire tick = (div_q == DIV_LAST) && !tif.restart;
    always_ff @(posedge clk_i) begin
        if (srst_i || tif.restart) begin
            div_q <= '0;
        end else if (tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + DIV_W'(1);
        end
    end

    assign tif.req = req_q;
    assign tif.ms_tick = tick;
    assign tif.on_ms = dly_ms(rail6_on_delay);
    assign tif.off_ms = dly_ms(rail6_off_delay);

    rsec_delay u_delay (
        .clk_i (clk_i),
        .srst_i (srst_i),
        .tmr (tif)
    );

    assign reg_rdata_o = rdata_q;
    assign reg_rvalid_o = rvalid_q;
    assign reg_err_o = err_q;
    assign rail6_en_o = tif.en;
    // Held value only; software is expected to leave it alone at runtime
    assign rail6_step_25mv_o = rail6_voltage_step;
    assign rail6_request_o = req_q;
    assign rail6_delay_busy_o = tif.busy;
endmodule

`default_nettype wire

// [sim/rail_six_enable_control_bench.sv]
`timescale 1ns/100ps
`default_nettype none

module rail_six_enable_control_bench;
    import rsec_pkg::*;
    localparam int M = 10;
    localparam int MS [8] = '{0, 2, 4, 8, 16, 24, 32, 64};
    localparam logic [5:0] SEL [8] = '{1, 2, 16, 8, 4, 12, 32, 0};
    logic clk = 0, srst = 1, wr = 0, rd = 0;
    logic [7:0] addr = 0, rdata, m;
    rsec_byte_t wdata = 0;
    logic rvalid, err, en, step, req, busy;
    rsec_pin_vec_t pins;
    rsec_pg_vec_t pg;
    int mismatches = 0, tests_run = 0, cyc = 0, n;
    always #4 clk = ~clk;
    rsec_top #(.MS_CYCLES(M)) i_dut (.clk_i(clk), .srst_i(srst),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .reg_err_o(err),
        .ctl_pin_i(pins), .rail_pg_i(pg), .rail6_en_o(en),
        .rail6_step_25mv_o(step), .rail6_request_o(req),
        .rail6_delay_busy_o(busy));
    rsec_pins_model i_pins (.clk_i(clk), .pin_o(pins), .pg_o(pg));
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1;
        check(rdata, e);
        check(rvalid, 1);
        check(err, a < 8'h16 || a > 8'h18);
    endtask
    // Edges from the pin change until enable reaches v, within tolerance
    task automatic edge_len(input logic v, input int c);
        n = 0;
        while (en !== v && n < 2000) begin
            settle(1);
            n++;
        end
        check(n >= MS[c] * M * 9 / 10 && n <= MS[c] * M * 11 / 10 + 4, 1);
    endtask
    task complete_run;
        $display("compares %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        srst <= 0;
        rreg(8'h16, 8'h00);
        rreg(8'h17, 8'hc0);
        rreg(8'h18, 8'h00);
        check(step, 0);
        wreg(8'h16, 8'hff);
        rreg(8'h16, 8'hff);
        wreg(8'h18, 8'hc0);
        rreg(8'h18, 8'hc0);
        wreg(8'h18, 8'h00);
        // Configuration phase: step size is set to 1 here; every later write to 8'h17 keeps bit 5 at 1
        wreg(8'h17, 8'h20);
        rreg(8'h17, 8'h20);
        check(step, 1);
        rreg(8'h19, 8'h00);
        $display("registers done");
        for (int c = 0; c < 8; c++) begin
            wreg(8'h17, {3'b111, c[2:0], 2'b11});
            i_pins.drive(SEL[c], 10'h000);
            settle(3);
            check(req, 1);
            check(en, 1);
            i_pins.drive(SEL[c] & (SEL[c] - 6'h1), 10'h000);
            settle(3);
            check(req, c == 7);
        end
        $display("sources done");
        for (int i = 0; i < 10; i++) begin
            m = ~(8'h1 << i);
            wreg(8'h16, m);
            wreg(8'h17, {6'h3f, i < 8 ? 2'b11 : ~(2'b1 << (i - 8))});
            i_pins.drive(6'h00, ~(10'h1 << i));
            settle(3);
            check(req, 0);
            wreg(8'h16, 8'hff);
            wreg(8'h17, 8'hff);
            settle(3);
            check(req, 1);
        end
        $display("masks done");
        wreg(8'h16, 8'h00);
        wreg(8'h17, 8'hfc);
        for (int c = 1; c < 8; c++) begin
            wreg(8'h18, {2'b00, c[2:0], c[2:0]});
            i_pins.drive(6'h00, 10'h3ff);
            edge_len(1, c);
            i_pins.drive(6'h00, 10'h000);
            edge_len(0, c);
        end
        wreg(8'h18, 8'h1b);
        i_pins.drive(6'h00, 10'h3ff);
        settle(20);
        check(busy, 1);
        i_pins.drive(6'h00, 10'h000);
        settle(100);
        check({en, busy}, 0);
        i_pins.drive(6'h00, 10'h3ff);
        edge_len(1, 3);
        check(step, 1);
        $display("delays done");
        // Reset in mid-run with the rail enabled
        @(posedge clk);
        srst <= 1;
        repeat (2) @(posedge clk);
        srst <= 0;
        rreg(8'h17, 8'hc0);
        check({en, step}, 0);
        $display("reset done");
        complete_run();
    end
endmodule

`default_nettype wire

// [sim/rsec_pins_model.sv]
`timescale 1ns/100ps
`default_nettype none

// Host side: drives control pins and the other rails' power-goods
module rsec_pins_model (
    input wire logic clk_i,              // Clock
    output var rsec_pkg::rsec_pin_vec_t pin_o, // Control pins 1..6
    output var rsec_pkg::rsec_pg_vec_t pg_o    // Power-goods
);
    import rsec_pkg::*;
    initial begin
        pin_o = '0;
        pg_o = '0;
    end
    // Levels change only just after a rising edge
    task automatic drive(input rsec_pin_vec_t p, input rsec_pg_vec_t g);
        @(posedge clk_i);
        pin_o <= p;
        pg_o <= g;
    endtask
endmodule

`default_nettype wire

// [sim/rsec_top_sva.sv]
`timescale 1ns/100ps
`default_nettype none
`include "rsec_params.svh"

module rsec_top_sva #(
    parameter int MS_CYCLES = 10 // Cycles per ms
) (
    input wire logic clk_i, // Clock
    input wire logic srst_i, // Reset
    input wire logic [7:0] reg_addr_i, // Offset
    input wire logic reg_wr_i, // Write
    input wire logic reg_rd_i, // Read
    input wire rsec_pkg::rsec_byte_t reg_wdata_i, // Data
    input wire logic [7:0] reg_rdata_o, // Data
    input wire logic reg_rvalid_o, // Valid
    input wire logic reg_err_o, // Error
    input wire rsec_pkg::rsec_pin_vec_t ctl_pin_i, // Pins
    input wire rsec_pkg::rsec_pg_vec_t rail_pg_i, // Power-goods
    input wire logic rail6_en_o, // Enable
    input wire logic rail6_step_25mv_o, // Step
    input wire logic rail6_request_o, // Request
    input wire logic rail6_delay_busy_o // Busy
);
    import rsec_pkg::*;
    localparam int MS_TAB [8] = '{0, 2, 4, 8, 16, 24, 32, 64};
    logic [7:0] a_q, b_q, d_q;
    logic req_q;
    int cnt_q;
    wire logic [7:0] src_w = {1'b1, ctl_pin_i[5], ctl_pin_i[2] & ctl_pin_i[3],
        ctl_pin_i[2], ctl_pin_i[3], ctl_pin_i[4], ctl_pin_i[1], ctl_pin_i[0]};
    wire logic pg_ok_w = &(rail_pg_i | {b_q[1:0], a_q});
    wire logic pin_w = src_w[b_q[4:2]];
    wire logic step_w = reg_wdata_i[5];
    wire integer on_w = MS_TAB[d_q[2:0]] * MS_CYCLES;
    wire integer off_w = MS_TAB[d_q[5:3]] * MS_CYCLES;
    // Shadow of the registers and length of the current request level
    always_ff @(posedge clk_i) begin
        req_q <= rail6_request_o;
        cnt_q <= (rail6_request_o != req_q) ? 0 : cnt_q + 1;
        if (srst_i) begin
            a_q <= `RSEC_RST_MASK_A;
            b_q <= `RSEC_RST_SRC_MASK_B;
            d_q <= `RSEC_RST_EDGE_DLY;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `RSEC_ADDR_MASK_A) a_q <= reg_wdata_i;
            if (reg_addr_i == `RSEC_ADDR_SRC_MASK_B) b_q <= reg_wdata_i;
            if (reg_addr_i == `RSEC_ADDR_EDGE_DLY) d_q <= reg_wdata_i;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    sequence s_req_up;
        $rose(rail6_request_o) && !rail6_en_o && d_q[2:0] != 3'h0;
    endsequence
    sequence s_on_end;
        $past(rail6_delay_busy_o) ##0 $rose(rail6_en_o);
    endsequence
    sequence s_off_end;
        $past(rail6_delay_busy_o) ##0 $fell(rail6_en_o);
    endsequence
    AST_RVALID: assert property (
        !$past(srst_i) |-> reg_rvalid_o == $past(reg_rd_i))
        else $error("read valid timing wrong");
    AST_UNMAPPED: assert property (
        (reg_rd_i || reg_wr_i) && !(reg_addr_i inside {[8'h16:8'h18]})
        |=> reg_err_o) else $error("unmapped access without error");
    AST_STEP: assert property (
        reg_wr_i && reg_addr_i == `RSEC_ADDR_SRC_MASK_B
        |=> rail6_step_25mv_o == $past(step_w)) else $error("step bit wrong");
    AST_PG_BLOCKS: assert property (
        !$past(srst_i) && !$past(pg_ok_w) |-> !rail6_request_o)
        else $error("request despite missing power-good");
    AST_PG_MASKED: assert property (
        !$past(srst_i) && $past(pg_ok_w) |-> rail6_request_o == $past(pin_w))
        else $error("request differs from selected source");
    AST_BUSY_START: assert property (
        s_req_up |=> rail6_delay_busy_o) else $error("on delay not started");
    AST_EN_CAUSE: assert property (
        $changed(rail6_en_o) |-> rail6_en_o == $past(rail6_request_o))
        else $error("enable moved against request");
    AST_ON_TIME: assert property (
        s_on_end |-> cnt_q >= on_w * 9 / 10 && cnt_q <= on_w * 11 / 10 + 4)
        else $error("on delay length wrong");
    AST_OFF_TIME: assert property (
        s_off_end |-> cnt_q >= off_w * 9 / 10 && cnt_q <= off_w * 11 / 10 + 4)
        else $error("off delay length wrong");
endmodule

bind rsec_top rsec_top_sva #(.MS_CYCLES(MS_CYCLES)) i_sva (
    .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .reg_err_o(reg_err_o), .ctl_pin_i(ctl_pin_i), .rail_pg_i(rail_pg_i),
    .rail6_en_o(rail6_en_o), .rail6_step_25mv_o(rail6_step_25mv_o),
    .rail6_request_o(rail6_request_o),
    .rail6_delay_busy_o(rail6_delay_busy_o));

`default_nettype wire
